/* include/dmom_pkg.sv */
// Package with register indices, field positions and carriers for the offset mapper
package dmom_pkg;
  localparam logic [7:0] IDX_BANK_OFFSET_ZERO = 8'h09;
  localparam logic [7:0] IDX_BANK_OFFSET_ONE = 8'h0a;
  localparam logic [7:0] IDX_WRITE_MODE_EXT = 8'h0b;
  localparam logic [7:0] IDX_SET_RESET = 8'h00;
  localparam logic [7:0] IDX_ENABLE_SET_RESET = 8'h01;
  localparam logic [7:0] IDX_GRAPHICS_MODE = 8'h05;
  localparam logic [7:0] IDX_FOREGROUND_EXT = 8'h10;
  localparam logic [7:0] IDX_BACKGROUND_EXT = 8'h11;
  localparam logic [7:0] RST_BANK_OFFSET = 8'h00;
  localparam logic [7:0] RST_WRITE_MODE_EXT = 8'h00;
  localparam logic [7:0] RST_GRAPHICS_REG = 8'h00;
  localparam logic [7:0] MASK_WRITE_MODE_EXT = 8'h3f;
  localparam logic [7:0] MASK_LOW_NIBBLE = 8'h0f;
  localparam int BIT_BANK_EN = 0;
  localparam int BIT_EIGHT_BYTE_ADDR = 1;
  localparam int BIT_EXT_WRITE = 2;
  localparam int BIT_EIGHT_BYTE_LATCH = 3;
  localparam int BIT_ENH_WRITE = 4;
  localparam int BIT_GRANULARITY = 5;
  localparam int BIT_GMODE_EXT = 2;
  localparam int BIT_PAGE_LSB = 4;
  localparam logic [4:0] BYTES_PER_XFER_NORMAL = 5'h01;
  localparam logic [4:0] BYTES_PER_XFER_EXT = 5'h08;
  localparam logic [4:0] BYTES_PER_XFER_ENH = 5'h10;
  localparam logic [3:0] LATCH_BYTES_NORMAL = 4'h4;
  localparam logic [3:0] LATCH_BYTES_WIDE = 4'h8;
  localparam logic [2:0] SHIFT_NONE = 3'h0;
  localparam logic [2:0] SHIFT_EIGHT = 3'h3;
  localparam logic [2:0] SHIFT_SIXTEEN = 3'h4;

  // Effective mode word seen by the data path
  typedef struct packed {
    logic bank_en;
    logic gran16;
    logic ext_write;
    logic enh_write;
    logic wide_latch;
    logic eight_byte_block_addressing;
    logic sixteen_byte_block_addressing;
    logic ext_gmode;
  } dmom_mode_s;

  // Indexed register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] data;
  } dmom_reg_req_s;
endpackage : dmom_pkg

/* logic/dmom_addr_calc.sv */
// Combinational host-address to display-memory address mapping
`timescale 1ns/1ps
module dmom_addr_calc (
  input wire logic [19:0] i_host_addr,
  input wire logic [7:0] i_offset,
  input wire logic i_force15,
  input wire logic i_gran16,
  input wire logic [2:0] i_shift,
  output logic [23:0] o_mapped_memory_addr
);
  logic [16:0] intermediate_bus_addr;
  logic [21:0] sum;
  logic [23:0] shifted;

  always_comb begin
    intermediate_bus_addr = {1'b0, i_force15 ? 1'b0 : i_host_addr[15], i_host_addr[14:0]};
    if (i_gran16) begin
      sum = {5'h00, intermediate_bus_addr} + {1'b0, i_offset[6:0], 14'h0000};
    end else begin
      sum = {5'h00, intermediate_bus_addr} + {2'h0, i_offset, 12'h000};
    end
    shifted = {2'h0, sum} << i_shift;
    o_mapped_memory_addr = shifted;
  end
endmodule : dmom_addr_calc

/* logic/dmom_mapper.sv */
// Offset mapper and write-mode extension register block
`timescale 1ns/1ps

// Functional notes
// - Offset zero adds at bits 19:12 in four-kbyte mode unless banking with host bit 15 set.
// - Offset one used only when banking and host bit 15 is one.
// - Banking bit chooses by host bit 15; otherwise offset zero always.
// - Offset one opens an extra 32K window at either granularity.
// - Granularity bit makes offset bits 6:0 add at address bits 20:14.
// - Sixteen-kbyte mode ignores page register low bit.
// - Enhanced plus extended writes shift host address left by four.
// - Enhanced mode writes up to 16 bytes per host byte.
// - Enhanced mode enables foreground and background color extension registers.
// - Enhanced mode: each write-mask bit covers two bytes.
// - Latch-width bit makes data latches eight bytes wide.
// - Extended mode writes eight bytes per host byte, sixteen with enhanced.
// - Extended mode honours graphics-mode bit 2 for write modes 4 and 5.
// - Extended mode widens set/reset, enable set/reset, write mask to 8 bits.
// - Enhanced bit honoured only while extended bit is set.
// - Extended bit falling clears upper nibbles of set/reset registers.
// - Eight-byte block bit shifts host address left by three unless enhanced mode is on (then four).
// - Intermediate bit 16 zero; bit 15 zero when banking or 64K map.
// - Four-kbyte mode adds full offset at 19:12, low 12 bits unchanged.
module dmom_mapper (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire dmom_pkg::dmom_reg_req_s i_reg_req,
  input wire logic [19:0] i_host_addr,
  input wire logic i_map_64k,
  input wire logic [7:0] i_sequencer_page_reg,
  input wire logic [7:0] i_plane_write_mask,
  output logic [7:0] o_rd_data,
  output logic [23:0] o_mapped_memory_addr,
  output logic [4:0] o_bytes_per_xfer,
  output logic [3:0] o_latch_bytes,
  output logic [15:0] o_byte_write_mask,
  output logic [7:0] o_set_reset,
  output logic [7:0] o_enable_set_reset,
  output logic [7:0] o_foreground_color_ext,
  output logic [7:0] o_background_color_ext,
  output logic o_ext_write_mode_45,
  output logic [7:0] o_page_eff,
  output dmom_pkg::dmom_mode_s o_mode
);
  logic [7:0] bank_offset_zero_r;
  logic [7:0] bank_offset_one_r;
  logic [7:0] write_mode_extensions_r;
  logic [7:0] set_reset_reg_r;
  logic [7:0] enable_set_reset_reg_r;
  logic [7:0] graphics_mode_reg_r;
  logic [7:0] foreground_color_ext_r;
  logic [7:0] background_color_ext_r;
  dmom_pkg::dmom_mode_s mode_nxt;
  logic use_one;
  logic [7:0] offset_sel;
  logic [2:0] shift_sel;
  logic [23:0] addr_nxt;
  logic [15:0] mask_nxt;
  logic [7:0] rd_nxt;
  logic wr_ext_fall;

  function automatic logic wr_hit(input dmom_pkg::dmom_reg_req_s req, input logic [7:0] idx);
    wr_hit = req.wr && (req.index == idx);
  endfunction : wr_hit

  function automatic logic [7:0] widen(input logic [7:0] v, input logic ext);
    widen = ext ? v : (v & dmom_pkg::MASK_LOW_NIBBLE);
  endfunction : widen

  always_comb begin
    mode_nxt.bank_en = write_mode_extensions_r[dmom_pkg::BIT_BANK_EN];
    mode_nxt.gran16 = write_mode_extensions_r[dmom_pkg::BIT_GRANULARITY];
    mode_nxt.ext_write = write_mode_extensions_r[dmom_pkg::BIT_EXT_WRITE];
    mode_nxt.enh_write = write_mode_extensions_r[dmom_pkg::BIT_ENH_WRITE] && mode_nxt.ext_write;
    mode_nxt.wide_latch = write_mode_extensions_r[dmom_pkg::BIT_EIGHT_BYTE_LATCH];
    mode_nxt.eight_byte_block_addressing = write_mode_extensions_r[dmom_pkg::BIT_EIGHT_BYTE_ADDR];
    mode_nxt.sixteen_byte_block_addressing = mode_nxt.enh_write;
    mode_nxt.ext_gmode = mode_nxt.ext_write && graphics_mode_reg_r[dmom_pkg::BIT_GMODE_EXT];
  end

  always_comb begin
    use_one = mode_nxt.bank_en && i_host_addr[15];
    offset_sel = use_one ? bank_offset_one_r : bank_offset_zero_r;
    // address shift select; host avoids both at once
    if (mode_nxt.sixteen_byte_block_addressing) begin
      shift_sel = dmom_pkg::SHIFT_SIXTEEN;
    end else if (mode_nxt.eight_byte_block_addressing) begin
      shift_sel = dmom_pkg::SHIFT_EIGHT;
    end else begin
      shift_sel = dmom_pkg::SHIFT_NONE;
    end
  end

  // address computation, second window via bank bit
  dmom_addr_calc u_addr_calc (
    .i_host_addr(i_host_addr),
    .i_offset(offset_sel),
    .i_force15(mode_nxt.bank_en || i_map_64k),
    .i_gran16(mode_nxt.gran16),
    .i_shift(shift_sel),
    .o_mapped_memory_addr(addr_nxt)
  );

  always_comb begin
    mask_nxt = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      if (mode_nxt.enh_write) begin
        // one mask bit per two bytes
        mask_nxt[2*i] = i_plane_write_mask[i];
        mask_nxt[2*i+1] = i_plane_write_mask[i];
      end else if (mode_nxt.ext_write) begin
        mask_nxt[i] = i_plane_write_mask[i];
      end else if (i < 4) begin
        mask_nxt[i] = i_plane_write_mask[i];
      end
    end
  end

  always_comb begin
    case (i_reg_req.index)
      dmom_pkg::IDX_BANK_OFFSET_ZERO: rd_nxt = bank_offset_zero_r;
      dmom_pkg::IDX_BANK_OFFSET_ONE: rd_nxt = bank_offset_one_r;
      dmom_pkg::IDX_WRITE_MODE_EXT: rd_nxt = write_mode_extensions_r;
      dmom_pkg::IDX_SET_RESET: rd_nxt = set_reset_reg_r;
      dmom_pkg::IDX_ENABLE_SET_RESET: rd_nxt = enable_set_reset_reg_r;
      dmom_pkg::IDX_GRAPHICS_MODE: rd_nxt = graphics_mode_reg_r;
      dmom_pkg::IDX_FOREGROUND_EXT: rd_nxt = mode_nxt.enh_write ? foreground_color_ext_r : 8'h00;
      dmom_pkg::IDX_BACKGROUND_EXT: rd_nxt = mode_nxt.enh_write ? background_color_ext_r : 8'h00;
      default: rd_nxt = 8'h00;
    endcase
  end

  assign wr_ext_fall = wr_hit(i_reg_req, dmom_pkg::IDX_WRITE_MODE_EXT)
                       && write_mode_extensions_r[dmom_pkg::BIT_EXT_WRITE]
                       && !i_reg_req.data[dmom_pkg::BIT_EXT_WRITE];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bank_offset_zero_r <= dmom_pkg::RST_BANK_OFFSET;
      bank_offset_one_r <= dmom_pkg::RST_BANK_OFFSET;
      write_mode_extensions_r <= dmom_pkg::RST_WRITE_MODE_EXT;
      graphics_mode_reg_r <= dmom_pkg::RST_GRAPHICS_REG;
    end else if (i_ce) begin
      if (wr_hit(i_reg_req, dmom_pkg::IDX_BANK_OFFSET_ZERO)) begin
        bank_offset_zero_r <= i_reg_req.data;
      end
      if (wr_hit(i_reg_req, dmom_pkg::IDX_BANK_OFFSET_ONE)) begin
        bank_offset_one_r <= i_reg_req.data;
      end
      if (wr_hit(i_reg_req, dmom_pkg::IDX_WRITE_MODE_EXT)) begin
        write_mode_extensions_r <= i_reg_req.data & dmom_pkg::MASK_WRITE_MODE_EXT;
      end
      if (wr_hit(i_reg_req, dmom_pkg::IDX_GRAPHICS_MODE)) begin
        graphics_mode_reg_r <= i_reg_req.data;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      set_reset_reg_r <= dmom_pkg::RST_GRAPHICS_REG;
      enable_set_reset_reg_r <= dmom_pkg::RST_GRAPHICS_REG;
    end else if (i_ce) begin
      // clear upper nibbles on extended bit fall
      if (wr_ext_fall) begin
        set_reset_reg_r <= set_reset_reg_r & dmom_pkg::MASK_LOW_NIBBLE;
        enable_set_reset_reg_r <= enable_set_reset_reg_r & dmom_pkg::MASK_LOW_NIBBLE;
      end
      if (wr_hit(i_reg_req, dmom_pkg::IDX_SET_RESET)) begin
        set_reset_reg_r <= widen(i_reg_req.data, mode_nxt.ext_write);
      end
      if (wr_hit(i_reg_req, dmom_pkg::IDX_ENABLE_SET_RESET)) begin
        enable_set_reset_reg_r <= widen(i_reg_req.data, mode_nxt.ext_write);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      foreground_color_ext_r <= dmom_pkg::RST_GRAPHICS_REG;
      background_color_ext_r <= dmom_pkg::RST_GRAPHICS_REG;
    end else if (i_ce) begin
      // color extension writable in enhanced mode
      if (mode_nxt.enh_write && wr_hit(i_reg_req, dmom_pkg::IDX_FOREGROUND_EXT)) begin
        foreground_color_ext_r <= i_reg_req.data;
      end
      if (mode_nxt.enh_write && wr_hit(i_reg_req, dmom_pkg::IDX_BACKGROUND_EXT)) begin
        background_color_ext_r <= i_reg_req.data;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
      o_mapped_memory_addr <= 24'h000000;
      o_bytes_per_xfer <= dmom_pkg::BYTES_PER_XFER_NORMAL;
      o_latch_bytes <= dmom_pkg::LATCH_BYTES_NORMAL;
      o_byte_write_mask <= 16'h0000;
      o_set_reset <= 8'h00;
      o_enable_set_reset <= 8'h00;
      o_foreground_color_ext <= 8'h00;
      o_background_color_ext <= 8'h00;
      o_ext_write_mode_45 <= 1'b0;
      o_page_eff <= 8'h00;
      o_mode <= '0;
    end else if (i_ce) begin
      o_rd_data <= i_reg_req.rd ? rd_nxt : o_rd_data;
      o_mapped_memory_addr <= addr_nxt;
      o_bytes_per_xfer <= mode_nxt.enh_write ? dmom_pkg::BYTES_PER_XFER_ENH :
                          mode_nxt.ext_write ? dmom_pkg::BYTES_PER_XFER_EXT : dmom_pkg::BYTES_PER_XFER_NORMAL;
      o_latch_bytes <= mode_nxt.wide_latch ? dmom_pkg::LATCH_BYTES_WIDE : dmom_pkg::LATCH_BYTES_NORMAL;
      o_byte_write_mask <= mask_nxt;
      o_set_reset <= set_reset_reg_r;
      o_enable_set_reset <= enable_set_reset_reg_r;
      o_foreground_color_ext <= mode_nxt.enh_write ? foreground_color_ext_r : 8'h00;
      o_background_color_ext <= mode_nxt.enh_write ? background_color_ext_r : 8'h00;
      o_ext_write_mode_45 <= mode_nxt.ext_gmode;
      // page low bit ignored in sixteen-kbyte mode
      o_page_eff <= mode_nxt.gran16 ? (i_sequencer_page_reg & ~(8'h01 << dmom_pkg::BIT_PAGE_LSB))
                                    : i_sequencer_page_reg;
      o_mode <= mode_nxt;
    end
  end

  chk_bank_sel_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && !write_mode_extensions_r[0] && !mode_nxt.gran16 |=>
      o_mapped_memory_addr[19:0] == (({4'h0, $past(i_host_addr[15:0])} + {$past(bank_offset_zero_r), 12'h000})
        << $past(shift_sel)) || $past(i_map_64k))
    else $error("offset zero mapping wrong");
  chk_bank_sel_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && use_one |-> offset_sel == bank_offset_one_r)
    else $error("offset one not selected");
  chk_bank_off_unused: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !mode_nxt.bank_en |-> offset_sel == bank_offset_zero_r)
    else $error("offset one used while banking off");
  chk_enh_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && !write_mode_extensions_r[2] |=> o_bytes_per_xfer != dmom_pkg::BYTES_PER_XFER_ENH)
    else $error("enhanced honoured without extended");
  chk_ext_fall_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && wr_ext_fall && !wr_hit(i_reg_req, 8'h00) && !wr_hit(i_reg_req, 8'h01) |=>
      set_reset_reg_r[7:4] == 4'h0 && enable_set_reset_reg_r[7:4] == 4'h0)
    else $error("upper nibbles not cleared");
  chk_latch_width: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && write_mode_extensions_r[3] |=> o_latch_bytes == 4'h8)
    else $error("latch not widened");
  chk_mask_double: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && mode_nxt.enh_write |=> o_byte_write_mask[1] == o_byte_write_mask[0])
    else $error("mask not doubled");
  chk_regs_readback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && wr_hit(i_reg_req, 8'h09) ##1 i_ce && i_reg_req.rd && i_reg_req.index == 8'h09 && !i_reg_req.wr
      |=> o_rd_data == $past(i_reg_req.data, 2))
    else $error("readback mismatch");
  chk_shift_four: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mode_nxt.enh_write |-> shift_sel == 3'h4)
    else $error("shift by four missing");
  chk_gran_sixteen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && mode_nxt.gran16 && shift_sel == dmom_pkg::SHIFT_NONE |=>
      o_mapped_memory_addr[13:0] == $past(i_host_addr[13:0]))
    else $error("sixteen-kbyte low bits disturbed");
  chk_low_unchanged: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && !mode_nxt.gran16 && shift_sel == dmom_pkg::SHIFT_NONE |=>
      o_mapped_memory_addr[11:0] == $past(i_host_addr[11:0]))
    else $error("four-kbyte low bits disturbed");
  chk_page_ignore: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && mode_nxt.gran16 |=> !o_page_eff[dmom_pkg::BIT_PAGE_LSB])
    else $error("page low bit not ignored");
  chk_bytes_enh: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && write_mode_extensions_r[dmom_pkg::BIT_ENH_WRITE] && write_mode_extensions_r[dmom_pkg::BIT_EXT_WRITE]
      |=> o_bytes_per_xfer == dmom_pkg::BYTES_PER_XFER_ENH)
    else $error("enhanced transfer size wrong");
  chk_bytes_ext: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && mode_nxt.ext_write && !mode_nxt.enh_write |=> o_bytes_per_xfer == dmom_pkg::BYTES_PER_XFER_EXT)
    else $error("extended transfer size wrong");
  chk_wmode_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && !write_mode_extensions_r[dmom_pkg::BIT_EXT_WRITE] |=> !o_ext_write_mode_45)
    else $error("write modes 4/5 without extended");
  chk_shift_eight: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && write_mode_extensions_r[dmom_pkg::BIT_EIGHT_BYTE_ADDR] && !mode_nxt.enh_write |=>
      o_mapped_memory_addr[3:0] == {$past(i_host_addr[0]), 3'h0})
    else $error("shift by three missing");
  chk_color_lock: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && !mode_nxt.enh_write |=> o_foreground_color_ext == 8'h00 && o_background_color_ext == 8'h00)
    else $error("color extension outside enhanced");
  chk_narrow_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_ce && !mode_nxt.ext_write && wr_hit(i_reg_req, dmom_pkg::IDX_SET_RESET) |=> set_reset_reg_r[7:4] == 4'h0)
    else $error("narrow set/reset widened");
  chk_force_fifteen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mode_nxt.bank_en || i_map_64k |-> u_addr_calc.intermediate_bus_addr[16:15] == 2'b00)
    else $error("intermediate bit 15 not forced");
  cov_bank_one: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_ce && use_one);
  cov_gran16: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_ce && mode_nxt.gran16);
  cov_enh: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_ce && mode_nxt.enh_write);
  cov_fall: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_ce && wr_ext_fall);
  cov_eight_block: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_ce && shift_sel == dmom_pkg::SHIFT_EIGHT);
endmodule : dmom_mapper

/* tb/dmom_host_model.sv */
// Host CPU model driving the indexed graphics register port
`timescale 1ns/1ps
module dmom_host_model #(
  parameter bit LINEAR_1MB = 1'b0
) (
  input wire logic i_ref_clk,
  output dmom_pkg::dmom_reg_req_s o_reg_req
);
  initial begin
    o_reg_req = '0;
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (idx == dmom_pkg::IDX_WRITE_MODE_EXT) begin
      if (v[dmom_pkg::BIT_ENH_WRITE]) v[dmom_pkg::BIT_EIGHT_BYTE_ADDR] = 1'b0;
      if (LINEAR_1MB) v[dmom_pkg::BIT_BANK_EN] = 1'b0;
    end
    @(posedge i_ref_clk);
    o_reg_req <= '{wr: 1'b1, rd: 1'b0, index: idx, data: v};
    @(posedge i_ref_clk);
    o_reg_req <= '0;
  endtask : wr

  // write then read back at once
  task automatic wr_rd(input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_reg_req <= '{wr: 1'b1, rd: 1'b0, index: idx, data: d};
    @(posedge i_ref_clk);
    o_reg_req <= '{wr: 1'b0, rd: 1'b1, index: idx, data: 8'h00};
    @(posedge i_ref_clk);
    o_reg_req <= '0;
  endtask : wr_rd

  task automatic rd(input logic [7:0] idx);
    @(posedge i_ref_clk);
    o_reg_req <= '{wr: 1'b0, rd: 1'b1, index: idx, data: 8'h00};
    @(posedge i_ref_clk);
    o_reg_req <= '0;
  endtask : rd
endmodule : dmom_host_model

/* tb/dmom_mapper_tb.sv */
// Self-checking bench for the offset mapper
`timescale 1ns/1ps
module dmom_mapper_tb;
  logic i_ref_clk;
  logic i_rst;
  dmom_pkg::dmom_reg_req_s reg_req;
  logic [19:0] host_addr;
  logic map_64k;
  logic [7:0] page_reg;
  logic [7:0] plane_mask;
  logic [7:0] rd_data;
  logic [23:0] mapped_addr;
  logic [4:0] bytes_xfer;
  logic [3:0] latch_bytes;
  logic [15:0] byte_mask;
  logic [7:0] set_reset;
  logic [7:0] en_set_reset;
  logic [7:0] fg_ext;
  logic [7:0] bg_ext;
  logic wm45;
  logic [7:0] page_eff;
  dmom_pkg::dmom_mode_s mode;
  int mismatches;
  int tests_run;
  logic [31:0] seed;
  logic [23:0] exp_addr[$];
  logic [7:0] exp_rd[$];
  logic chk_a;
  logic chk_a_d1 = 1'b0;
  logic rd_d1 = 1'b0;
  logic ce;
  logic [23:0] exp_a;
  logic [7:0] off0;
  logic [7:0] off1;
  logic [7:0] mtab[10] = '{8'h00, 8'h01, 8'h21, 8'h20, 8'h02, 8'h04, 8'h14, 8'h10, 8'h08, 8'h35};

  dmom_host_model host (.i_ref_clk(i_ref_clk), .o_reg_req(reg_req));

  dmom_mapper DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(ce), .i_reg_req(reg_req),
    .i_host_addr(host_addr), .i_map_64k(map_64k), .i_sequencer_page_reg(page_reg),
    .i_plane_write_mask(plane_mask), .o_rd_data(rd_data), .o_mapped_memory_addr(mapped_addr),
    .o_bytes_per_xfer(bytes_xfer), .o_latch_bytes(latch_bytes), .o_byte_write_mask(byte_mask),
    .o_set_reset(set_reset), .o_enable_set_reset(en_set_reset), .o_foreground_color_ext(fg_ext),
    .o_background_color_ext(bg_ext), .o_ext_write_mode_45(wm45), .o_page_eff(page_eff), .o_mode(mode));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  function automatic logic [23:0] map_exp(input logic [19:0] a, input logic [7:0] m, input logic m64);
    logic [23:0] xa;
    logic [7:0] off;
    xa = {9'h000, a[14:0]};
    if (!m[0] && !m64) xa[15] = a[15];
    off = (m[0] && a[15]) ? off1 : off0;
    xa = m[5] ? xa + {3'h0, off[6:0], 14'h0000} : xa + {4'h0, off, 12'h000};
    if (m[2] && m[4]) xa = xa << 4;
    else if (m[1]) xa = xa << 3;
    map_exp = xa;
  endfunction : map_exp

  task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic end_sim;
    $display("[INFO] comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic drive_addr(input logic [7:0] m);
    logic [19:0] a;
    seed = xs(seed);
    a = seed[19:0];
    @(posedge i_ref_clk);
    host_addr <= a;
    map_64k <= seed[23];
    chk_a <= 1'b1;
    exp_addr.push_back(map_exp(a, m, seed[23]));
  endtask : drive_addr

  task automatic check_modes(input logic [7:0] m);
    logic enh;
    logic [15:0] dbl;
    enh = m[2] && m[4];
    for (int b = 0; b < 8; b++) begin
      dbl[2 * b] = plane_mask[b];
      dbl[2 * b + 1] = plane_mask[b];
    end
    check(bytes_xfer, enh ? 5'h10 : (m[2] ? 5'h08 : 5'h01), "bytes per transfer");
    check(latch_bytes, m[3] ? 4'h8 : 4'h4, "latch width");
    check(wm45, m[2], "write mode 4/5");
    check(page_eff, m[5] ? (page_reg & 8'hef) : page_reg, "page field");
    check(fg_ext, enh ? 8'h5a : 8'h00, "foreground ext");
    check(bg_ext, enh ? 8'ha5 : 8'h00, "background ext");
    check(mode, {m[0], m[5], m[2], enh, m[3], m[1], enh, m[2]}, "mode word");
    if (enh) check(byte_mask, dbl, "doubled mask");
    else check(byte_mask, m[2] ? {8'h00, plane_mask} : {12'h000, plane_mask[3:0]}, "plain mask");
  endtask : check_modes

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // Results monitor: read data and mapped address register one edge after launch and are checked on the second
  always @(posedge i_ref_clk) begin
    chk_a_d1 <= chk_a;
    rd_d1 <= reg_req.rd;
    if (chk_a_d1) check(mapped_addr, exp_addr.pop_front(), "mapped address");
    if (rd_d1) check(rd_data, exp_rd.pop_front(), "read back");
  end

  initial begin
    repeat (5000) @(posedge i_ref_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    i_rst = 1'b1;
    host_addr = 20'h00000;
    map_64k = 1'b0;
    page_reg = 8'h00;
    plane_mask = 8'h00;
    chk_a = 1'b0;
    ce = 1'b1;
    mismatches = 0;
    tests_run = 0;
    seed = 32'h9d26;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      exp_rd.push_back(8'h00);
      host.rd(dmom_pkg::IDX_BANK_OFFSET_ZERO + k[7:0]);
    end
    host.wr(8'h3f, 8'h77);
    exp_rd.push_back(8'h00);
    host.rd(8'h3f);
    host.wr(dmom_pkg::IDX_GRAPHICS_MODE, 8'h04);
    $display("[INFO] reset and unmapped test done");
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      off0 = seed[7:0];
      off1 = seed[15:8];
      page_reg <= seed[23:16];
      plane_mask <= seed[31:24];
      exp_rd.push_back(off0);
      host.wr_rd(dmom_pkg::IDX_BANK_OFFSET_ZERO, off0);
      host.wr(dmom_pkg::IDX_BANK_OFFSET_ONE, off1);
      host.wr(dmom_pkg::IDX_WRITE_MODE_EXT, mtab[i]);
      host.wr(dmom_pkg::IDX_FOREGROUND_EXT, 8'h5a);
      host.wr(dmom_pkg::IDX_BACKGROUND_EXT, 8'ha5);
      exp_rd.push_back(off1);
      host.rd(dmom_pkg::IDX_BANK_OFFSET_ONE);
      exp_rd.push_back(mtab[i] & dmom_pkg::MASK_WRITE_MODE_EXT);
      host.rd(dmom_pkg::IDX_WRITE_MODE_EXT);
      repeat (3) @(posedge i_ref_clk);
      check_modes(mtab[i]);
      repeat (6) drive_addr(mtab[i]);
      @(posedge i_ref_clk);
      chk_a <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      $display("[INFO] mode %h test done", mtab[i]);
    end
    host.wr(dmom_pkg::IDX_WRITE_MODE_EXT, 8'h04);
    host.wr(dmom_pkg::IDX_SET_RESET, 8'hff);
    host.wr(dmom_pkg::IDX_ENABLE_SET_RESET, 8'hff);
    repeat (3) @(posedge i_ref_clk);
    check(set_reset, 8'hff, "wide set/reset");
    host.wr(dmom_pkg::IDX_WRITE_MODE_EXT, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    check(set_reset, 8'h0f, "set/reset cleared");
    check(en_set_reset, 8'h0f, "enable set/reset cleared");
    host.wr(dmom_pkg::IDX_SET_RESET, 8'hf3);
    repeat (3) @(posedge i_ref_clk);
    check(set_reset, 8'h03, "narrow set/reset");
    $display("[INFO] extended write fall test done");
    // Clock enable low must hold address output and ignore writes
    exp_a = map_exp(host_addr, 8'h00, map_64k);
    ce <= 1'b0;
    host_addr <= ~host_addr;
    host.wr(dmom_pkg::IDX_BANK_OFFSET_ZERO, ~off0);
    repeat (2) @(posedge i_ref_clk);
    check(mapped_addr, exp_a, "frozen address");
    ce <= 1'b1;
    exp_rd.push_back(off0);
    host.rd(dmom_pkg::IDX_BANK_OFFSET_ZERO);
    repeat (2) @(posedge i_ref_clk);
    $display("[INFO] clock enable freeze test done");
    end_sim();
  end
endmodule : dmom_mapper_tb
